//--- hw/fcv_bank.sv
// Fan configuration, voltage readout and core-undervolt sleep logic
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module fcv_bank #(
	parameter int SMOOTH_W = 16,
	parameter int TEMP_W   = 8
) (
	// Clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 nrst_i,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [9:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// Converter samples
	input  wire fcv_pkg::fcv_sample_s sample_i,
	input  wire logic                 sample_valid_i,
	// Temperature compare for thermal override
	input  wire logic [TEMP_W-1:0]    temp_i,
	input  wire logic [TEMP_W-1:0]    temp_limit_i,
	input  wire logic [TEMP_W-1:0]    temp_hyst_i,
	// Pins from outside
	input  wire logic                 thermal_override_n_i,
	input  wire logic                 standby_supply_i,
	// Fan engine side
	input  wire logic                 manual_mode_i,
	input  wire logic [SMOOTH_W-1:0]  smooth_r1_i,
	input  wire logic [SMOOTH_W-1:0]  smooth_loc_i,
	input  wire logic [SMOOTH_W-1:0]  smooth_r2_i,
	output logic      [SMOOTH_W+2:0]  smooth_r1_o,
	output logic      [SMOOTH_W+2:0]  smooth_loc_o,
	output logic      [SMOOTH_W+2:0]  smooth_r2_o,
	output fcv_pkg::fcv_fan_ctrl_s    fan_ctrl_o,
	// Interrupt
	output logic                      irq_o
);
	import fcv_pkg::*;

	initial begin
		if (SMOOTH_W < 1 || SMOOTH_W > 24)
			$error("SMOOTH_W out of range");
		if (TEMP_W < 1 || TEMP_W > 16)
			$error("TEMP_W out of range");
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	localparam int OUT_W = SMOOTH_W + 3;
	function automatic logic [OUT_W-1:0] scale_smooth(
		input logic [SMOOTH_W-1:0] base,
		input logic                slow,
		input logic                extra
	);
		logic [63:0] t;
		t = 64'(base);
		if (slow)
			t = t * 64'(SLOW_FACTOR);
		if (extra)
			t = (t * 64'(EXTRA_PERMIL)) / 64'(PERMIL);
		return t[OUT_W-1:0];
	endfunction

	function automatic logic [7:0] high_byte(input logic [ADC_W-1:0] v);
		return v[ADC_W-1:LSB_W];
	endfunction

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	logic       req;
	logic       wr;
	logic       rd;
	logic [7:0] idx;
	logic [7:0] wbyte;
	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign idx   = wb_adr_i[9:2];
	assign wbyte = wb_dat_i[7:0];
	assign wr    = req && wb_we_i && wb_sel_i[0];
	assign rd    = req && !wb_we_i;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [2:0] ovr_sync;
	logic [2:0] stby_sync;
	logic       ovr_pin;
	logic       on_standby;
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			ovr_sync  <= 3'h7;
			stby_sync <= 3'h0;
		end else begin
			ovr_sync  <= {ovr_sync[1:0], thermal_override_n_i};
			stby_sync <= {stby_sync[1:0], standby_supply_i};
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			ovr_pin    <= 1'b0;
			on_standby <= 1'b0;
		end else begin
			if (ovr_sync[1] == ovr_sync[2])
				ovr_pin <= !ovr_sync[2];
			if (stby_sync[1] == stby_sync[2])
				on_standby <= stby_sync[2];
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	logic [7:0] fan_behaviour_config;
	logic [7:0] thermal_hysteresis_config;
	logic       lock;
	logic [7:0] core_low_limit;
	logic [7:0] irq_mask;
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			fan_behaviour_config <= RST_FAN_BEHAVIOUR;
		else if (wr && idx == IDX_FAN_BEHAVIOUR)
			fan_behaviour_config <= wbyte;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			thermal_hysteresis_config <= RST_THERMAL_HYST;
		else if (wr && idx == IDX_THERMAL_HYST && !lock)
			thermal_hysteresis_config <= wbyte & HYST_WRITABLE;
	end

	// Lock is write-once: only a reset clears it
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			lock <= 1'b0;
		else if (wr && idx == IDX_LOCK_CTRL && wbyte[BIT_LOCK])
			lock <= 1'b1;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			core_low_limit <= RST_CORE_LOW_LIMIT;
			irq_mask       <= RST_IRQ;
		end else if (wr) begin
			if (idx == IDX_CORE_LOW_LIMIT)
				core_low_limit <= wbyte;
			if (idx == IDX_IRQ_MASK)
				irq_mask <= wbyte;
		end
	end

	// ------------------------------------------------------------------
	// Voltage readings with extended-resolution freeze
	// ------------------------------------------------------------------
	// Freeze bits in channel order 2.5 V, core, supply, 5.0 V, 12 V
	fcv_sample_s reading;
	logic [4:0]  frozen;
	logic [4:0]  hi_read;
	logic        ext1_rd;
	logic        ext2_rd;
	always_comb begin
		hi_read = 5'h00;
		if (rd) begin
			hi_read[0] = (idx == IDX_READING_2V5);
			hi_read[1] = (idx == IDX_READING_CORE);
			hi_read[2] = (idx == IDX_READING_SUPPLY);
			hi_read[3] = (idx == IDX_READING_5V0);
			hi_read[4] = (idx == IDX_READING_12V);
		end
	end

	assign ext1_rd = rd && idx == IDX_EXT_RES_1;
	assign ext2_rd = rd && idx == IDX_EXT_RES_2;

	// A freeze set by an extended read wins over a high-byte read clear
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			frozen <= 5'h00;
		else
			frozen <= (frozen & ~hi_read)
				| {ext2_rd, {4{ext1_rd}}};
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			reading <= '0;
		end else if (sample_valid_i) begin
			if (!frozen[0])
				reading.v2p5 <= sample_i.v2p5;
			if (!frozen[1])
				reading.core <= sample_i.core;
			if (!frozen[2])
				reading.supply <= sample_i.supply;
			if (!frozen[3])
				reading.v5 <= sample_i.v5;
			if (!frozen[4])
				reading.v12 <= sample_i.v12;
		end
	end

	// ------------------------------------------------------------------
	// Thermal override with optional hysteresis
	// ------------------------------------------------------------------
	logic              temp_over;
	logic [TEMP_W:0]   release_lvl;
	logic              release_hit;
	assign release_lvl = thermal_hysteresis_config[BIT_HYST_OFF]
		? {1'b0, temp_limit_i}
		: {1'b0, temp_limit_i} - {1'b0, temp_hyst_i};
	assign release_hit = release_lvl[TEMP_W]
		|| {1'b0, temp_i} < release_lvl;
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			temp_over <= 1'b0;
		else if (temp_i >= temp_limit_i)
			temp_over <= 1'b1;
		else if (release_hit || thermal_hysteresis_config[BIT_HYST_OFF])
			temp_over <= 1'b0;
	end

	logic override_now;
	logic override_prev;
	// Manual mode masks override unless hand-control is set
	assign override_now = (ovr_pin || temp_over)
		&& (!manual_mode_i
		|| fan_behaviour_config[BIT_HAND_CTRL]);

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			override_prev <= 1'b0;
		else
			override_prev <= override_now;
	end

	// ------------------------------------------------------------------
	// Core-undervolt sleep
	// ------------------------------------------------------------------
	fcv_pwr_e     pwr;
	logic         core_low;
	logic [15:0]  spin_cnt;
	logic         undervolt_evt;
	assign core_low = fan_behaviour_config[BIT_UNDERVOLT] && on_standby
		&& high_byte(reading.core) < core_low_limit;
	assign undervolt_evt = pwr == PWR_NORMAL && core_low;

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			pwr      <= PWR_NORMAL;
			spin_cnt <= 16'h0000;
		end else begin
			case (pwr)
			PWR_NORMAL: begin
				if (core_low)
					pwr <= PWR_SLEEP;
			end
			PWR_SLEEP: begin
				if (!core_low) begin
					pwr      <= PWR_SPINUP;
					spin_cnt <= 16'(SPINUP_CYC - 1);
				end
			end
			PWR_SPINUP: begin
				if (spin_cnt == 16'h0000)
					pwr <= PWR_NORMAL;
				else
					spin_cnt <= spin_cnt - 16'h0001;
			end
			default: pwr <= PWR_NORMAL;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status, read-to-clear, set wins
	// ------------------------------------------------------------------
	logic [7:0] irq_status;
	logic [7:0] irq_set;
	always_comb begin
		irq_set = 8'h00;
		irq_set[BIT_IRQ_CORE_LOW] = undervolt_evt;
		irq_set[BIT_IRQ_OVERRIDE] = override_now && !override_prev;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			irq_status <= RST_IRQ;
		else if (rd && idx == IDX_IRQ_STATUS)
			irq_status <= irq_set;
		else
			irq_status <= irq_status | irq_set;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_status & ~irq_mask);
	end

	// ------------------------------------------------------------------
	// Fan-side outputs
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			smooth_r1_o  <= '0;
			smooth_loc_o <= '0;
			smooth_r2_o  <= '0;
		end else begin
			smooth_r1_o  <= scale_smooth(smooth_r1_i,
				fan_behaviour_config[BIT_SMOOTH_R1],
				fan_behaviour_config[BIT_EXTRA]);
			smooth_loc_o <= scale_smooth(smooth_loc_i,
				fan_behaviour_config[BIT_SMOOTH_LOC],
				fan_behaviour_config[BIT_EXTRA]);
			smooth_r2_o  <= scale_smooth(smooth_r2_i,
				fan_behaviour_config[BIT_SMOOTH_R2],
				fan_behaviour_config[BIT_EXTRA]);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			fan_ctrl_o <= '0;
		end else begin
			fan_ctrl_o.sync_follower  <= fan_behaviour_config[BIT_FOLLOWER];
			fan_ctrl_o.sync_leader    <= fan_behaviour_config[BIT_LEADER];
			// Not gated by fan enable or sleep state
			fan_ctrl_o.force_full     <= override_now;
			fan_ctrl_o.spinup         <= pwr == PWR_SPINUP;
			fan_ctrl_o.hot_monitor_en <= pwr != PWR_SLEEP;
		end
	end

	// ------------------------------------------------------------------
	// Read mux and acknowledge
	// ------------------------------------------------------------------
	logic [7:0] rdata;
	always_comb begin
		case (idx)
		IDX_FAN_BEHAVIOUR:  rdata = fan_behaviour_config;
		IDX_THERMAL_HYST:   rdata = thermal_hysteresis_config;
		IDX_READING_2V5:    rdata = high_byte(reading.v2p5);
		IDX_READING_CORE:   rdata = high_byte(reading.core);
		IDX_READING_SUPPLY: rdata = high_byte(reading.supply);
		IDX_READING_5V0:    rdata = high_byte(reading.v5);
		IDX_READING_12V:    rdata = high_byte(reading.v12);
		IDX_LOCK_CTRL:      rdata = {6'h00, lock, 1'b0};
		IDX_IRQ_STATUS:     rdata = irq_status;
		IDX_CORE_LOW_LIMIT: rdata = core_low_limit;
		IDX_IRQ_MASK:       rdata = irq_mask;
		IDX_EXT_RES_1:      rdata = {reading.v5[LSB_W-1:0],
			reading.supply[LSB_W-1:0], reading.core[LSB_W-1:0],
			reading.v2p5[LSB_W-1:0]};
		IDX_EXT_RES_2:      rdata = {6'h00, reading.v12[LSB_W-1:0]};
		default:            rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (rd)
				wb_dat_o <= {24'h00_0000, rdata};
		end
	end

endmodule

`default_nettype wire

//--- hw/fcv_pkg.sv
// Shared constants and carrier types of the fan configuration and readout bank
package fcv_pkg;

	// ------------------------------------------------------------------
	// Register indices; the byte address is four times the index
	// ------------------------------------------------------------------
	localparam logic [7:0] IDX_FAN_BEHAVIOUR   = 8'h10;
	localparam logic [7:0] IDX_THERMAL_HYST    = 8'h11;
	localparam logic [7:0] IDX_READING_2V5     = 8'h20;
	localparam logic [7:0] IDX_READING_CORE    = 8'h21;
	localparam logic [7:0] IDX_READING_SUPPLY  = 8'h22;
	localparam logic [7:0] IDX_READING_5V0     = 8'h23;
	localparam logic [7:0] IDX_READING_12V     = 8'h24;
	localparam logic [7:0] IDX_LOCK_CTRL       = 8'h40;
	localparam logic [7:0] IDX_IRQ_STATUS      = 8'h41;
	localparam logic [7:0] IDX_CORE_LOW_LIMIT  = 8'h46;
	localparam logic [7:0] IDX_IRQ_MASK        = 8'h74;
	localparam logic [7:0] IDX_EXT_RES_1       = 8'h76;
	localparam logic [7:0] IDX_EXT_RES_2       = 8'h77;

	// ------------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_FAN_BEHAVIOUR  = 8'h00;
	localparam logic [7:0] RST_THERMAL_HYST   = 8'h00;
	localparam logic [7:0] RST_READING        = 8'h00;
	localparam logic [7:0] RST_CORE_LOW_LIMIT = 8'h00;
	localparam logic [7:0] RST_IRQ            = 8'h00;
	localparam int BIT_SMOOTH_R1    = 0;
	localparam int BIT_SMOOTH_LOC   = 1;
	localparam int BIT_SMOOTH_R2    = 2;
	localparam int BIT_HAND_CTRL    = 3;
	localparam int BIT_FOLLOWER     = 4;
	localparam int BIT_LEADER       = 5;
	localparam int BIT_UNDERVOLT    = 6;
	localparam int BIT_EXTRA        = 7;
	localparam int BIT_HYST_OFF     = 0;
	localparam int BIT_LOCK         = 1;
	localparam int BIT_IRQ_OVERRIDE = 0;
	localparam int BIT_IRQ_CORE_LOW = 1;
	localparam logic [7:0] HYST_WRITABLE = 8'h01;

	// ------------------------------------------------------------------
	// Smoothing scale and timing
	// ------------------------------------------------------------------
	localparam int SLOW_FACTOR  = 4;
	localparam int EXTRA_PERMIL = 1392;
	localparam int PERMIL       = 1000;
	localparam int CLK_MHZ      = 200;
	localparam int SPINUP_US    = 2;
	localparam int SPINUP_CYC   = SPINUP_US * CLK_MHZ;
	localparam int ADC_W        = 10;
	localparam int LSB_W        = 2;

	typedef struct packed {
		logic [ADC_W-1:0] v12;
		logic [ADC_W-1:0] v5;
		logic [ADC_W-1:0] supply;
		logic [ADC_W-1:0] core;
		logic [ADC_W-1:0] v2p5;
	} fcv_sample_s;

	typedef struct packed {
		logic sync_leader;
		logic sync_follower;
		logic force_full;
		logic spinup;
		logic hot_monitor_en;
	} fcv_fan_ctrl_s;

	typedef enum logic [1:0] {
		PWR_NORMAL,
		PWR_SLEEP,
		PWR_SPINUP
	} fcv_pwr_e;

endpackage

//--- test/fcv_bank_props.sv
// Assertion checker for the fan configuration and readout bank
`timescale 1ns/1ps
`default_nettype none
module fcv_bank_props
	import fcv_pkg::*;
#(
	parameter int SMOOTH_W = 16,
	parameter int TEMP_W   = 8
) (
	// Clock, reset and bus
	input wire logic                   core_clk_i,
	input wire logic                   nrst_i,
	input wire logic                   wb_cyc_i,
	input wire logic                   wb_stb_i,
	input wire logic                   wb_we_i,
	input wire logic [9:0]             wb_adr_i,
	input wire logic [3:0]             wb_sel_i,
	input wire logic [31:0]            wb_dat_i,
	input wire logic [31:0]            wb_dat_o,
	input wire logic                   wb_ack_o,
	// Fan side
	input wire logic                   thermal_override_n_i,
	input wire logic                   manual_mode_i,
	input wire logic [SMOOTH_W-1:0]    smooth_r1_i,
	input wire logic [SMOOTH_W-1:0]    smooth_loc_i,
	input wire logic [SMOOTH_W-1:0]    smooth_r2_i,
	input wire logic [SMOOTH_W+2:0]    smooth_r1_o,
	input wire logic [SMOOTH_W+2:0]    smooth_loc_o,
	input wire logic [SMOOTH_W+2:0]    smooth_r2_o,
	input wire fcv_pkg::fcv_fan_ctrl_s fan_ctrl_o
);
	// ----------------------------------------------------------------
	// Shadow of the fan behaviour register and a spin-up counter
	// ----------------------------------------------------------------
	logic [7:0] cfg;
	logic       live;
	int         spin_n;

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			cfg <= 8'h00;
		else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
			&& wb_adr_i[9:2] == IDX_FAN_BEHAVIOUR)
			cfg <= wb_dat_i[7:0];
	end
	always_ff @(posedge core_clk_i) begin
		live <= nrst_i;
	end
	always_ff @(posedge core_clk_i) begin
		spin_n <= (!nrst_i || !fan_ctrl_o.spinup) ? 0 : spin_n + 1;
	end

	function automatic logic [SMOOTH_W+2:0] scale(logic [SMOOTH_W-1:0] b,
		logic s, logic e);
		logic [63:0] t;
		t = s ? 64'(b) * SLOW_FACTOR : 64'(b);
		if (e)
			t = t * EXTRA_PERMIL / PERMIL;
		return t[SMOOTH_W+2:0];
	endfunction

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	chk_scale_r1: assert property (live |-> smooth_r1_o ==
		scale($past(smooth_r1_i), $past(cfg[0]), $past(cfg[7])))
		else $error("remote 1 smoothing time wrong");
	chk_scale_loc: assert property (live |-> smooth_loc_o ==
		scale($past(smooth_loc_i), $past(cfg[1]), $past(cfg[7])))
		else $error("local smoothing time wrong");
	chk_scale_r2: assert property (live |-> smooth_r2_o ==
		scale($past(smooth_r2_i), $past(cfg[2]), $past(cfg[7])))
		else $error("remote 2 smoothing time wrong");
	chk_force_pin: assert property ((!thermal_override_n_i &&
		!manual_mode_i)[*7] |-> fan_ctrl_o.force_full)
		else $error("override pin did not force fans");
	chk_force_hand: assert property ((!thermal_override_n_i &&
		manual_mode_i && cfg[3])[*7] |-> fan_ctrl_o.force_full)
		else $error("override lost in manual mode");
	chk_follower_bit: assert property (live |->
		fan_ctrl_o.sync_follower == $past(cfg[4]))
		else $error("follower role wrong");
	chk_leader_bit: assert property (live |->
		fan_ctrl_o.sync_leader == $past(cfg[5]))
		else $error("leader role wrong");
	chk_spin_hot: assert property (fan_ctrl_o.spinup |->
		fan_ctrl_o.hot_monitor_en)
		else $error("hot monitor off during spin-up");
	chk_spin_len: assert property ($fell(fan_ctrl_o.spinup) |->
		spin_n == SPINUP_CYC)
		else $error("spin-up length wrong");
	chk_read_width: assert property (wb_ack_o |->
		wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");

	cover property ($fell(fan_ctrl_o.spinup));
	cover property ($rose(fan_ctrl_o.force_full));
	cover property (wb_ack_o && cfg[7]);
endmodule

bind fcv_bank fcv_bank_props #(.SMOOTH_W(SMOOTH_W), .TEMP_W(TEMP_W))
	i_fcv_bank_props (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.thermal_override_n_i(thermal_override_n_i),
	.manual_mode_i(manual_mode_i), .smooth_r1_i(smooth_r1_i),
	.smooth_loc_i(smooth_loc_i), .smooth_r2_i(smooth_r2_i),
	.smooth_r1_o(smooth_r1_o), .smooth_loc_o(smooth_loc_o),
	.smooth_r2_o(smooth_r2_o), .fan_ctrl_o(fan_ctrl_o));
`default_nettype wire

//--- test/fcv_bank_test.sv
// Self-checking bench for the fan configuration and readout bank
`timescale 1ns/1ps
`default_nettype none
module fcv_bank_test;
	import fcv_pkg::*;

	logic          core_clk   = 1'b0;
	logic          nrst       = 1'b0;
	logic          cyc        = 1'b0;
	logic          stb        = 1'b0;
	logic          we         = 1'b0;
	logic [9:0]    adr        = 10'h000;
	logic [31:0]   wdat       = 32'h0;
	logic [3:0]    sel        = 4'h1;
	logic          sv         = 1'b1;
	logic [31:0]   rdat;
	logic          ack;
	fcv_sample_s   smp        = '0;
	logic [7:0]    temp       = 8'h00;
	logic          pin_n      = 1'b1;
	logic          stby       = 1'b0;
	logic          man        = 1'b0;
	logic [15:0]   s1         = 16'h0;
	logic [15:0]   s2         = 16'h0;
	logic [15:0]   s3         = 16'h0;
	logic [18:0]   o1, o2, o3;
	fcv_fan_ctrl_s fc;
	logic          irq;
	logic [7:0]    q, v;
	fcv_sample_s   a, b;
	int            seed       = 13957;
	int            n_mismatch = 0;
	int            tests_run  = 0;

	fcv_bank #(.SMOOTH_W(16), .TEMP_W(8)) i_fcv_bank (
		.core_clk_i(core_clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .sample_i(smp), .sample_valid_i(sv),
		.temp_i(temp), .temp_limit_i(8'd100), .temp_hyst_i(8'd10),
		.thermal_override_n_i(pin_n), .standby_supply_i(stby),
		.manual_mode_i(man), .smooth_r1_i(s1), .smooth_loc_i(s2),
		.smooth_r2_i(s3), .smooth_r1_o(o1), .smooth_loc_o(o2),
		.smooth_r2_o(o3), .fan_ctrl_o(fc), .irq_o(irq));

	// ----------------------------------------------------------------
	// Clock, random smoothing bases, helpers
	// ----------------------------------------------------------------
	always #2.5 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		s1 <= 16'($random(seed));
		s2 <= 16'($random(seed));
		s3 <= 16'($random(seed));
	end

	function automatic logic [7:0] msb(fcv_sample_s s, int i);
		logic [49:0] w;
		w = s >> (10 * i);
		return w[9:2];
	endfunction

	function automatic logic [7:0] ext1(fcv_sample_s s);
		return {s.v5[1:0], s.supply[1:0], s.core[1:0], s.v2p5[1:0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Classic cycle: hold until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		do
			@(posedge core_clk);
		while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		wb(1'b0, idx, 8'h00);
		chk($sformatf("register %h", idx), {24'h0, q}, {24'h0, e});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic print_verdict;
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		print_verdict;
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		tick(8);
		nrst <= 1'b1;
		tick(4);
		rd(IDX_FAN_BEHAVIOUR, RST_FAN_BEHAVIOUR);
		rd(IDX_THERMAL_HYST, RST_THERMAL_HYST);
		for (int i = 0; i < 5; i++)
			rd(IDX_READING_2V5 + 8'(i), RST_READING);
		wb(1'b1, IDX_READING_CORE, 8'hff);
		rd(IDX_READING_CORE, 8'h00);
		wb(1'b1, 8'h50, 8'hff);
		rd(8'h50, 8'h00);
		// A write without the low byte lane must be dropped
		sel <= 4'he;
		wb(1'b1, IDX_CORE_LOW_LIMIT, 8'h5a);
		sel <= 4'h1;
		rd(IDX_CORE_LOW_LIMIT, RST_CORE_LOW_LIMIT);
		for (int i = 0; i < 10; i++) begin
			v = (i < 2) ? {8{i[0]}} : 8'($random(seed));
			wb(1'b1, IDX_FAN_BEHAVIOUR, v);
			tick(3);
			rd(IDX_FAN_BEHAVIOUR, v);
			chk("sync roles", {fc.sync_leader, fc.sync_follower}, v[5:4]);
		end
		// Extended read freezes the high bytes until each is read
		a = 50'({$random(seed), $random(seed)});
		smp <= a;
		tick(2);
		rd(IDX_EXT_RES_1, ext1(a));
		rd(IDX_EXT_RES_2, {6'h0, a.v12[1:0]});
		b = 50'({$random(seed), $random(seed)});
		smp <= b;
		tick(2);
		for (int i = 0; i < 5; i++)
			rd(IDX_READING_2V5 + 8'(i), msb(a, i));
		for (int i = 0; i < 5; i++)
			rd(IDX_READING_2V5 + 8'(i), msb(b, i));
		// Without a valid strobe the readings hold
		sv <= 1'b0;
		smp <= a;
		tick(3);
		rd(IDX_READING_2V5, msb(b, 0));
		sv <= 1'b1;
		// Override by pin, manual mode, temperature hysteresis
		wb(1'b1, IDX_FAN_BEHAVIOUR, 8'h00);
		pin_n <= 1'b0;
		tick(9);
		chk("force by pin", fc.force_full, 1'b1);
		wb(1'b0, IDX_IRQ_STATUS, 8'h00);
		chk("status override", q, 8'h01);
		man <= 1'b1;
		tick(8);
		chk("force manual", fc.force_full, 1'b0);
		wb(1'b1, IDX_FAN_BEHAVIOUR, 8'h08);
		tick(8);
		chk("force hand", fc.force_full, 1'b1);
		pin_n <= 1'b1;
		man <= 1'b0;
		temp <= 8'd100;
		tick(8);
		chk("force temp", fc.force_full, 1'b1);
		temp <= 8'd95;
		tick(8);
		chk("force hyst", fc.force_full, 1'b1);
		wb(1'b1, IDX_THERMAL_HYST, 8'h01);
		rd(IDX_THERMAL_HYST, 8'h01);
		tick(4);
		chk("force no hyst", fc.force_full, 1'b0);
		temp <= 8'd0;
		// Core undervolt sleep, alert mask and recovery
		wb(1'b0, IDX_IRQ_STATUS, 8'h00);
		tick(2);
		chk("irq idle", irq, 1'b0);
		wb(1'b1, IDX_CORE_LOW_LIMIT, 8'h80);
		a = b;
		a.core = 10'h040;
		smp <= a;
		stby <= 1'b1;
		wb(1'b1, IDX_FAN_BEHAVIOUR, 8'h40);
		tick(8);
		chk("hot monitor off", fc.hot_monitor_en, 1'b0);
		chk("alert", irq, 1'b1);
		wb(1'b1, IDX_IRQ_MASK, 8'h02);
		tick(3);
		chk("alert masked", irq, 1'b0);
		wb(1'b1, IDX_IRQ_MASK, 8'h00);
		tick(3);
		chk("alert unmasked", irq, 1'b1);
		wb(1'b0, IDX_IRQ_STATUS, 8'h00);
		chk("status core low", q, 8'h02);
		tick(3);
		chk("alert cleared", irq, 1'b0);
		a.core = 10'h3ff;
		smp <= a;
		tick(4);
		chk("spin-up", fc.spinup, 1'b1);
		chk("hot monitor on", fc.hot_monitor_en, 1'b1);
		tick(420);
		chk("spin-up over", fc.spinup, 1'b0);
		// Lock, then a second reset
		wb(1'b1, IDX_LOCK_CTRL, 8'h02);
		wb(1'b1, IDX_THERMAL_HYST, 8'h00);
		rd(IDX_THERMAL_HYST, 8'h01);
		nrst <= 1'b0;
		tick(6);
		nrst <= 1'b1;
		tick(4);
		rd(IDX_THERMAL_HYST, RST_THERMAL_HYST);
		wb(1'b1, IDX_THERMAL_HYST, 8'h01);
		rd(IDX_THERMAL_HYST, 8'h01);
		print_verdict;
	end
endmodule
`default_nettype wire
